// ===== tcu_core.v
// Purpose: Instruction parser and state of four timing/counting units.
// Assumes: Host characters, match hits and assignments are synchronous.
// Notes:   Match comparison and unit/port assignment parsing are outside.
`timescale 1ns/1ps
`default_nettype none
`include "tcu_map.vh"

module tcu_core #(
  parameter integer MS_CYCLES = `TCU_MS_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Host instruction characters
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  output wire        rx_ready,
  // Host character reads
  input  wire        rd_req,
  output wire [7:0]  rd_data,
  output wire        rd_valid,
  // Unit to port assignment
  input  wire        asg_we,
  input  wire [1:0]  asg_unit,
  input  wire [1:0]  asg_mode,
  input  wire [1:0]  asg_port,
  // Match comparator
  input  wire [3:0]  match_armed,
  input  wire [3:0]  match_hit,
  // External input lines
  input  wire        ext_wired,
  input  wire [3:0]  ext_in_n,
  // Events and errors
  output reg  [3:0]  port_event_ff,
  output reg  [3:0]  active_ff,
  output reg         err_bad_ff,
  output reg         err_mismatch_ff,
  output reg         err_not_now_ff
);

  // ---------------------------------------------------------------
  // Parser states and millisecond divider
  // ---------------------------------------------------------------
  localparam [1:0]  PS_IDLE = 2'h0;
  localparam [1:0]  PS_UNIT = 2'h1;
  localparam [1:0]  PS_CMD  = 2'h2;
  localparam [1:0]  PS_ARG  = 2'h3;
  localparam [16:0] MS_LAST = MS_CYCLES[16:0] - 17'h0_0001;

  reg [16:0]          ms_cnt_ff;
  reg                 ms_tick_ff;
  reg [1:0]           ps_ff;
  reg [1:0]           unit_ff;
  reg [7:0]           cmd_ff;
  reg [`TCU_MS_W-1:0] arg_ff;
  reg [3:0]           ndig_ff;
  reg                 ovf_ff;
  reg [1:0]           mode_ff   [0:3];
  reg [1:0]           port_ff   [0:3];
  reg [`TCU_MS_W-1:0] delay_ff  [0:3];
  reg [`TCU_MS_W-1:0] period_ff [0:3];
  reg [3:0]           delay_en_ff;
  reg [3:0]           period_en_ff;
  reg [3:0]           start_ff;
  reg [3:0]           clr_ff;
  reg                 load_ff;
  reg [3:0]           nxt_port_event;
  reg                 clash;
  integer             i;

  wire [3:0]            fire;
  wire [3:0]            done;
  wire [`TCU_BCD_W-1:0] count [0:3];

  // ---------------------------------------------------------------
  // Character classes
  // ---------------------------------------------------------------
  function fn_in_range;
    input [7:0] ch;
    input [7:0] lo;
    input [7:0] hi;
    begin
      fn_in_range = (ch >= lo) && (ch <= hi);
    end
  endfunction

  function [`TCU_MS_W-1:0] fn_mul10_add;
    input [`TCU_MS_W-1:0] a;
    input [7:0]           ch;
    reg   [7:0]           d;
    begin
      d = ch - `TCU_CH_0;
      fn_mul10_add = (a << 3) + (a << 1) + {19'h0_0000, d};
    end
  endfunction

  wire       take     = rx_valid;
  wire       is_lf    = (rx_data == `TCU_CH_LF);
  wire       is_digit = fn_in_range(rx_data, `TCU_CH_0, `TCU_CH_9);
  wire       is_upper = fn_in_range(rx_data, `TCU_CH_UP_LO, `TCU_CH_UP_HI);
  wire [7:0] unit_off = rx_data - `TCU_CH_1;
  wire       unit_ok  = fn_in_range(rx_data, `TCU_CH_1, `TCU_CH_4);
  // An argument ends at the line feed or at the next instruction letter.
  wire       arg_end  = take && (ps_ff == PS_ARG) && (is_lf || is_upper);
  wire [1:0] eff_ps   = (ps_ff == PS_ARG) ? PS_IDLE : ps_ff;
  wire       u_active = active_ff[unit_ff];
  wire [1:0] u_mode   = mode_ff[unit_ff];

  assign rx_ready = 1'b1;

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      ms_cnt_ff  <= 17'h0_0000;
      ms_tick_ff <= 1'b0;
    end else if (ms_cnt_ff == MS_LAST) begin
      ms_cnt_ff  <= 17'h0_0000;
      ms_tick_ff <= 1'b1;
    end else begin
      ms_cnt_ff  <= ms_cnt_ff + 17'h0_0001;
      ms_tick_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Event routing and assignment clash check
  // ---------------------------------------------------------------
  always @* begin
    nxt_port_event = 4'h0;
    clash = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (fire[i] && mode_ff[i] == `TCU_MODE_OUT) begin
        nxt_port_event[port_ff[i]] = 1'b1;
      end
      if (i[1:0] != asg_unit && mode_ff[i] == asg_mode &&
          port_ff[i] == asg_port && asg_mode != `TCU_MODE_NONE) begin
        clash = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Instruction parser and unit state
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      ps_ff           <= PS_IDLE;
      unit_ff         <= 2'h0;
      cmd_ff          <= 8'h00;
      arg_ff          <= {`TCU_MS_W{1'b0}};
      ndig_ff         <= 4'h0;
      ovf_ff          <= 1'b0;
      active_ff       <= 4'h0;
      delay_en_ff     <= 4'h0;
      period_en_ff    <= 4'h0;
      start_ff        <= 4'h0;
      clr_ff          <= 4'h0;
      load_ff         <= 1'b0;
      port_event_ff   <= 4'h0;
      err_bad_ff      <= 1'b0;
      err_mismatch_ff <= 1'b0;
      err_not_now_ff  <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        mode_ff[i]   <= `TCU_MODE_NONE;
        port_ff[i]   <= 2'h0;
        delay_ff[i]  <= {`TCU_MS_W{1'b0}};
        period_ff[i] <= {`TCU_MS_W{1'b0}};
      end
      mode_ff[`TCU_RST_UNIT] <= `TCU_MODE_IN;
      port_ff[`TCU_RST_UNIT] <= `TCU_RST_PORT;
    end else begin
      start_ff        <= 4'h0;
      clr_ff          <= 4'h0;
      load_ff         <= 1'b0;
      err_bad_ff      <= 1'b0;
      err_mismatch_ff <= 1'b0;
      err_not_now_ff  <= 1'b0;
      port_event_ff   <= nxt_port_event;
      active_ff       <= active_ff & ~done;

      if (asg_we) begin
        if (active_ff[asg_unit]) begin
          err_not_now_ff <= 1'b1;
        end else if (clash) begin
          err_mismatch_ff <= 1'b1;
        end else begin
          mode_ff[asg_unit] <= asg_mode;
          port_ff[asg_unit] <= asg_port;
        end
      end

      if (arg_end) begin
        if (u_mode != `TCU_MODE_OUT) begin
          err_mismatch_ff <= 1'b1;
        end else if (u_active) begin
          err_not_now_ff <= 1'b1;
        end else if (ovf_ff || (ndig_ff != 4'h0 && arg_ff == 0)) begin
          err_bad_ff <= 1'b1;
        end else if (cmd_ff == `TCU_CH_D) begin
          delay_en_ff[unit_ff] <= (ndig_ff != 4'h0);
          delay_ff[unit_ff]    <= arg_ff;
        end else begin
          period_en_ff[unit_ff] <= (ndig_ff != 4'h0);
          period_ff[unit_ff]    <= arg_ff;
        end
      end

      // Anything not upper case, a digit or a line feed is a comment.
      if (take && is_lf) begin
        if (ps_ff == PS_UNIT || ps_ff == PS_CMD) begin
          err_bad_ff <= 1'b1;
        end
        ps_ff <= PS_IDLE;
      end else if (take && is_upper) begin
        ps_ff <= PS_IDLE;
        case (eff_ps)
          PS_IDLE: begin
            if (rx_data == `TCU_CH_HALTALL) begin
              active_ff <= 4'h0;
            end else if (rx_data == `TCU_CH_FIREALL) begin
              active_ff <= 4'hf;
              start_ff  <= 4'hf;
            end else if (rx_data == `TCU_CH_U) begin
              ps_ff <= PS_UNIT;
            end else begin
              err_bad_ff <= 1'b1;
            end
          end
          PS_CMD: begin
            if (rx_data == `TCU_CH_H || rx_data == `TCU_CH_G) begin
              if (u_mode == `TCU_MODE_NONE) begin
                err_mismatch_ff <= 1'b1;
              end else begin
                active_ff[unit_ff] <= (rx_data == `TCU_CH_G);
                start_ff[unit_ff]  <= (rx_data == `TCU_CH_G);
              end
            end else if (rx_data == `TCU_CH_D || rx_data == `TCU_CH_P) begin
              ps_ff   <= PS_ARG;
              cmd_ff  <= rx_data;
              arg_ff  <= {`TCU_MS_W{1'b0}};
              ndig_ff <= 4'h0;
              ovf_ff  <= 1'b0;
            end else if (rx_data == `TCU_CH_V || rx_data == `TCU_CH_C) begin
              if (u_mode != `TCU_MODE_IN) begin
                err_mismatch_ff <= 1'b1;
              end else if (rx_data == `TCU_CH_V) begin
                load_ff <= 1'b1;
              end else begin
                clr_ff[unit_ff] <= 1'b1;
              end
            end else begin
              err_bad_ff <= 1'b1;
            end
          end
          default: begin
            err_bad_ff <= 1'b1;
          end
        endcase
      end else if (take && is_digit) begin
        if (ps_ff == PS_UNIT) begin
          if (unit_ok) begin
            unit_ff <= unit_off[1:0];
            ps_ff   <= PS_CMD;
          end else begin
            err_bad_ff <= 1'b1;
            ps_ff      <= PS_IDLE;
          end
        end else if (ps_ff == PS_ARG) begin
          if (ndig_ff == `TCU_MAX_DIGITS) begin
            ovf_ff <= 1'b1;
          end else begin
            arg_ff  <= fn_mul10_add(arg_ff, rx_data);
            ndig_ff <= ndig_ff + 4'h1;
          end
        end else if (ps_ff == PS_CMD) begin
          err_bad_ff <= 1'b1;
          ps_ff      <= PS_IDLE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Units and output buffer
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_unit
      tcu_unit u_unit (
        .clk         (clk),
        .reset       (reset),
        .ms_tick     (ms_tick_ff),
        .mode        (mode_ff[g]),
        .active      (active_ff[g]),
        .start       (start_ff[g]),
        .clr         (clr_ff[g]),
        .ext_en      (!ext_wired || !ext_in_n[port_ff[g]]),
        .delay_en    (delay_en_ff[g]),
        .delay_val   (delay_ff[g]),
        .period_en   (period_en_ff[g]),
        .period_val  (period_ff[g]),
        .match_armed (match_armed[g]),
        .match_hit   (match_hit[g]),
        .fire_ff     (fire[g]),
        .done_ff     (done[g]),
        .count_ff    (count[g])
      );
    end
  endgenerate

  tcu_txbuf u_txbuf (
    .clk         (clk),
    .reset       (reset),
    .load        (load_ff),
    .load_val    (count[unit_ff]),
    .rd_req      (rd_req),
    .rd_data_ff  (rd_data),
    .rd_valid_ff (rd_valid)
  );

endmodule
`default_nettype wire

// ===== tcu_map.vh
// Purpose: Shared constants of the timing/counting units.
// Assumes: Characters arrive as 8-bit ASCII codes.
// Notes:   Included by every design file of the block.
`ifndef TCU_MAP_VH
`define TCU_MAP_VH

// ---------------------------------------------------------------
// Characters
// ---------------------------------------------------------------
`define TCU_CH_LF      8'h0a
`define TCU_CH_0       8'h30
`define TCU_CH_1       8'h31
`define TCU_CH_4       8'h34
`define TCU_CH_9       8'h39
`define TCU_CH_UP_LO   8'h41
`define TCU_CH_UP_HI   8'h5a
`define TCU_CH_HALTALL 8'h41
`define TCU_CH_C       8'h43
`define TCU_CH_D       8'h44
`define TCU_CH_FIREALL 8'h46
`define TCU_CH_G       8'h47
`define TCU_CH_H       8'h48
`define TCU_CH_P       8'h50
`define TCU_CH_U       8'h55
`define TCU_CH_V       8'h56

// ---------------------------------------------------------------
// Unit modes and reset assignment
// ---------------------------------------------------------------
`define TCU_MODE_NONE  2'h0
`define TCU_MODE_OUT   2'h1
`define TCU_MODE_IN    2'h2
`define TCU_RST_UNIT   2'h1
`define TCU_RST_PORT   2'h0

// ---------------------------------------------------------------
// Widths, counts and timing
// ---------------------------------------------------------------
`define TCU_MS_W       27
`define TCU_BCD_W      40
`define TCU_MAX_DIGITS 4'h8
`define TCU_VAL_DIGITS 4'ha
`define TCU_BCD_NINE   4'h9
`define TCU_TMR_LAST   27'h000_0001
`define TCU_MS_NS      1000000
`define TCU_CLK_NS     10
`define TCU_MS_CYCLES  (`TCU_MS_NS / `TCU_CLK_NS)

`endif

// ===== tcu_unit.v
// Purpose: One timing/counting unit: interval timer and BCD counter.
// Assumes: ms_tick is a one-cycle pulse once per millisecond.
// Notes:   Halting is owned by the core; done asks it to halt.
`timescale 1ns/1ps
`default_nettype none
`include "tcu_map.vh"

module tcu_unit (
  // Clock and reset
  input  wire                    clk,
  input  wire                    reset,
  // Control from the core
  input  wire                    ms_tick,
  input  wire [1:0]              mode,
  input  wire                    active,
  input  wire                    start,
  input  wire                    clr,
  input  wire                    ext_en,
  // Specifications
  input  wire                    delay_en,
  input  wire [`TCU_MS_W-1:0]    delay_val,
  input  wire                    period_en,
  input  wire [`TCU_MS_W-1:0]    period_val,
  input  wire                    match_armed,
  input  wire                    match_hit,
  // Results
  output reg                     fire_ff,
  output reg                     done_ff,
  output reg  [`TCU_BCD_W-1:0]   count_ff
);

  localparam [1:0] PH_IDLE  = 2'h0;
  localparam [1:0] PH_MATCH = 2'h1;
  localparam [1:0] PH_DELAY = 2'h2;
  localparam [1:0] PH_PER   = 2'h3;

  reg [1:0]           ph_ff;
  reg [`TCU_MS_W-1:0] tmr_ff;

  // Counting in BCD makes the ten-digit readout a plain shift.
  function [`TCU_BCD_W-1:0] fn_bcd_inc;
    input [`TCU_BCD_W-1:0] v;
    integer k;
    reg     c;
    begin
      c = 1'b1;
      fn_bcd_inc = v;
      for (k = 0; k < `TCU_VAL_DIGITS; k = k + 1) begin
        if (c) begin
          if (v[4*k +: 4] == `TCU_BCD_NINE) begin
            fn_bcd_inc[4*k +: 4] = 4'h0;
          end else begin
            fn_bcd_inc[4*k +: 4] = v[4*k +: 4] + 4'h1;
            c = 1'b0;
          end
        end
      end
    end
  endfunction

  wire last = ms_tick && (tmr_ff == `TCU_TMR_LAST);

  always @(posedge clk) begin
    if (reset) begin
      ph_ff    <= PH_IDLE;
      tmr_ff   <= {`TCU_MS_W{1'b0}};
      fire_ff  <= 1'b0;
      done_ff  <= 1'b0;
      count_ff <= {`TCU_BCD_W{1'b0}};
    end else begin
      fire_ff <= 1'b0;
      done_ff <= 1'b0;
      if (clr) begin
        count_ff <= {`TCU_BCD_W{1'b0}};
      end else if (mode == `TCU_MODE_IN && active && ms_tick && ext_en) begin
        count_ff <= fn_bcd_inc(count_ff);
      end
      if (start && mode == `TCU_MODE_OUT) begin
        // A restart drops any interval in progress.
        if (match_armed) begin
          ph_ff <= PH_MATCH;
        end else if (delay_en) begin
          ph_ff  <= PH_DELAY;
          tmr_ff <= delay_val;
        end else if (period_en) begin
          ph_ff  <= PH_PER;
          tmr_ff <= period_val;
        end else begin
          ph_ff <= PH_IDLE;
        end
      end else if (!active || mode != `TCU_MODE_OUT) begin
        ph_ff <= PH_IDLE;
      end else begin
        case (ph_ff)
          PH_MATCH: begin
            if (match_hit) begin
              if (delay_en) begin
                ph_ff  <= PH_DELAY;
                tmr_ff <= delay_val;
              end else begin
                fire_ff <= 1'b1;
                if (period_en) begin
                  ph_ff  <= PH_PER;
                  tmr_ff <= period_val;
                end else begin
                  done_ff <= 1'b1;
                  ph_ff   <= PH_IDLE;
                end
              end
            end
          end
          PH_DELAY: begin
            if (last) begin
              fire_ff <= 1'b1;
              if (period_en) begin
                ph_ff  <= PH_PER;
                tmr_ff <= period_val;
              end else begin
                done_ff <= 1'b1;
                ph_ff   <= PH_IDLE;
              end
            end else if (ms_tick) begin
              tmr_ff <= tmr_ff - `TCU_TMR_LAST;
            end
          end
          PH_PER: begin
            if (last) begin
              fire_ff <= 1'b1;
              tmr_ff  <= period_val;
            end else if (ms_tick) begin
              tmr_ff <= tmr_ff - `TCU_TMR_LAST;
            end
          end
          default: begin
            ph_ff <= PH_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== tcu_txbuf.v
// Purpose: Output buffer that hands the host one character per read.
// Assumes: rd_req is a one-cycle pulse per host read.
// Notes:   A new load displaces whatever is still pending.
`timescale 1ns/1ps
`default_nettype none
`include "tcu_map.vh"

module tcu_txbuf (
  // Clock and reset
  input  wire                  clk,
  input  wire                  reset,
  // Load side
  input  wire                  load,
  input  wire [`TCU_BCD_W-1:0] load_val,
  // Host read side
  input  wire                  rd_req,
  output reg  [7:0]            rd_data_ff,
  output reg                   rd_valid_ff
);

  reg [`TCU_BCD_W-1:0] sh_ff;
  reg [3:0]            left_ff;

  always @(posedge clk) begin
    if (reset) begin
      sh_ff       <= {`TCU_BCD_W{1'b0}};
      left_ff     <= 4'h0;
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_req;
      if (rd_req) begin
        if (left_ff != 4'h0) begin
          rd_data_ff <= {4'h3, sh_ff[`TCU_BCD_W-1 -: 4]};
          sh_ff      <= {sh_ff[`TCU_BCD_W-5:0], 4'h0};
          left_ff    <= left_ff - 4'h1;
        end else begin
          // Terminates the number, or answers a read with nothing queued.
          rd_data_ff <= `TCU_CH_LF;
        end
      end
      if (load) begin
        sh_ff   <= load_val;
        left_ff <= `TCU_VAL_DIGITS;
      end
    end
  end

endmodule
`default_nettype wire

// ===== tcu_host.sv
// Purpose: Host model that types instructions and reads characters.
// Assumes: The parser never stalls, so one character goes per cycle.
// Notes:   Idle data is inverted so a stale character cannot pass.
`timescale 1ns/1ps
`default_nettype none
module tcu_host (
  input  wire logic       clk,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rd_req
);
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rd_req = 1'b0;
  end
  // Unit digits stay within one to four unless a refusal is wanted.
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk) #1;
      rx_data = s[i];
      rx_valid = 1'b1;
    end
    @(posedge clk) #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
  task automatic rd();
    @(posedge clk) #1;
    rd_req = 1'b1;
    @(posedge clk) #1;
    rd_req = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tcu_core_chk.sv
// Purpose: Port checks of the timing/counting unit core.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into the core at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module tcu_core_chk #(
  parameter integer MS_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       rd_req,
  input wire logic       rd_valid,
  input wire logic [3:0] active_ff,
  input wire logic       err_bad_ff,
  input wire logic       err_mismatch_ff,
  input wire logic       err_not_now_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire lower = rx_valid && rx_data >= 8'h61 && rx_data <= 8'h7a;
  wire any_err = err_bad_ff || err_mismatch_ff || err_not_now_ff;
  wire halt_ch = rx_valid && rx_data == 8'h41;
  wire fire_ch = rx_valid && rx_data == 8'h46;
  wire go_ch = fire_ch || (rx_valid && rx_data == 8'h47);
  sequence unit_s;
    rx_valid && rx_data == 8'h55;
  endsequence
  sequence bad_unit_s;
    unit_s ##1 rx_valid && (rx_data == 8'h35 || rx_data == 8'h0a);
  endsequence
  ready_const_a: assert property (rx_ready)
    else $error("parser stalled");
  lower_quiet_a: assert property (lower |=> !any_err)
    else $error("comment character raised an error");
  unit_range_a: assert property (bad_unit_s |=> err_bad_ff)
    else $error("bad unit selector accepted");
  read_answer_a: assert property (rd_req |=> rd_valid)
    else $error("read left unanswered");
  read_pulse_a: assert property (!rd_req |=> !rd_valid)
    else $error("read data without a read");
  halt_all_a: assert property (halt_ch |=> active_ff == 4'h0)
    else $error("halt all left a unit active");
  fire_all_a: assert property (fire_ch |=> active_ff[1])
    else $error("activate all missed unit two");
  go_cause_a: assert property (
    $rose(active_ff[0]) |-> $past(go_ch))
    else $error("unit one started without a command");
endmodule
bind tcu_core tcu_core_chk #(.MS_CYCLES(MS_CYCLES)) chk (
  .clk(clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rd_req(rd_req), .rd_valid(rd_valid),
  .active_ff(active_ff), .err_bad_ff(err_bad_ff),
  .err_mismatch_ff(err_mismatch_ff), .err_not_now_ff(err_not_now_ff)
);
`default_nettype wire

// ===== timing_counting_units_tb.sv
// Purpose: Self-checking bench of the timing/counting unit core.
// Assumes: A shortened millisecond of MS clock cycles.
// Notes:   Results are matched in order against a queue of notes.
`timescale 1ns/1ps
`default_nettype none
module timing_counting_units_tb;
  localparam integer MS = 4;
  logic        clk, reset, asg_we, ext_wired;
  logic [1:0]  asg_unit, asg_mode, asg_port;
  logic [3:0]  ext_in_n, match_armed, match_hit;
  wire  [7:0]  rx_data, rd_data;
  wire         rx_valid, rx_ready, rd_req, rd_valid;
  wire  [3:0]  port_event_ff, active_ff;
  wire         err_bad_ff, err_mismatch_ff, err_not_now_ff;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          seed = 32'h2c69_705f;
  int          k, t0, t1, t2;
  logic [15:0] exp_q[$];
  string       bad_cmd[7] = '{"U1D0\n", "U1D123456789\n", "U3V",
                              "U2D5\n", "U5A", "U\n", "Q"};
  logic [2:0]  bad_err[7] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4};
  tcu_core #(.MS_CYCLES(MS)) dut (
    .clk(clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .asg_we(asg_we), .asg_unit(asg_unit),
    .asg_mode(asg_mode), .asg_port(asg_port), .match_armed(match_armed),
    .match_hit(match_hit), .ext_wired(ext_wired), .ext_in_n(ext_in_n),
    .port_event_ff(port_event_ff), .active_ff(active_ff),
    .err_bad_ff(err_bad_ff), .err_mismatch_ff(err_mismatch_ff),
    .err_not_now_ff(err_not_now_ff)
  );
  tcu_host host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rd_req(rd_req));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic take(input logic [15:0] seen);
    logic [15:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 16'hffff;
    check("result", seen, e);
  endtask
  always @(posedge clk) begin
    if (!reset && rd_valid !== 1'b0) take({8'h10, rd_data});
    if (!reset && port_event_ff !== 4'h0) take({12'h200, port_event_ff});
    if (!reset && {err_bad_ff, err_mismatch_ff, err_not_now_ff} !== 3'h0)
      take({13'h0600, err_bad_ff, err_mismatch_ff, err_not_now_ff});
  end
  // Active span is a whole number of milliseconds, so tick phase is moot.
  task automatic run_unit2(input int n);
    host.send("U2G");
    repeat (n * MS - 4) @(posedge clk);
    host.send("U2H");
  endtask
  task automatic read_value(input int v);
    host.send("U2 value V");
    repeat (2) @(posedge clk);
    for (int i = 9; i >= 0; i--) begin
      exp_q.push_back({8'h10, 8'h30 + 8'(v / 10 ** i % 10)});
      host.rd();
    end
    exp_q.push_back(16'h100a);
    host.rd();
  endtask
  task automatic wait_event(output int t);
    int n;
    n = 0;
    while (port_event_ff === 4'h0 && n < 200) begin
      @(posedge clk) #1;
      n++;
    end
    t = cyc;
    @(posedge clk) #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    reset = 1'b1;
    asg_we = 1'b0;
    asg_unit = 2'h0;
    asg_mode = 2'h0;
    asg_port = 2'h0;
    ext_wired = 1'b0;
    ext_in_n = 4'hf;
    match_armed = 4'h0;
    match_hit = 4'h0;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    exp_q.push_back(16'h100a);
    host.rd();
    k = 1 + ($unsigned($random(seed)) % 6);
    host.send("U2C");
    run_unit2(k);
    read_value(k);
    repeat (3 * MS) @(posedge clk);
    read_value(k);
    host.send("U2C");
    read_value(0);
    $display("counter test done");
    ext_wired = 1'b1;
    run_unit2(2);
    read_value(0);
    ext_in_n = 4'he;
    run_unit2(2);
    read_value(2);
    ext_wired = 1'b0;
    $display("external enable test done");
    @(posedge clk) #1;
    asg_we = 1'b1;
    asg_mode = 2'h1;
    asg_port = 2'h3;
    @(posedge clk) #1;
    asg_we = 1'b0;
    foreach (bad_cmd[i]) begin
      exp_q.push_back({13'h0600, bad_err[i]});
      host.send(bad_cmd[i]);
      repeat (3) @(posedge clk);
    end
    $display("refusal test done");
    host.send("U1D3\n");
    exp_q.push_back(16'h2008);
    host.send("U1G");
    t0 = cyc;
    wait_event(t1);
    check("delay", 16'(t1 - t0 >= 2 * MS && t1 - t0 <= 3 * MS + 4), 16'h1);
    check("halted", {12'h000, active_ff}, 16'h0);
    repeat (4 * MS) @(posedge clk);
    $display("delay test done");
    host.send("U1D\n");
    host.send("U1P2\n");
    exp_q.push_back(16'h2008);
    exp_q.push_back(16'h2008);
    host.send("U1G");
    wait_event(t1);
    wait_event(t2);
    check("period", 16'(t2 - t1), 16'(2 * MS));
    exp_q.push_back(16'h3001);
    exp_q.push_back(16'h2008);
    host.send("U1P5\n");
    wait_event(t0);
    check("unchanged", 16'(t0 - t2), 16'(2 * MS));
    host.send("U1H");
    host.send("FA");
    repeat (4 * MS) @(posedge clk);
    $display("period test done");
    // A lone match fires once and then leaves the unit halted.
    match_armed = 4'h1;
    host.send("U1P\n");
    exp_q.push_back(16'h2008);
    host.send("U1G");
    @(posedge clk) #1;
    match_hit = 4'h1;
    @(posedge clk) #1;
    match_hit = 4'h0;
    wait_event(t1);
    check("match halt", {12'h000, active_ff}, 16'h0);
    match_armed = 4'h0;
    $display("match test done");
    check("drained", 16'(exp_q.size()), 16'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
